// [core/bypass_protection_sequencer.sv]
// bypass supervisory sequencer: soft-ramp control, protection timers and avalon register slave
`timescale 1ns/100ps
module bypass_protection_sequencer
  import bypass_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // avalon-mm slave
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // operating mode and commands (pins)
  input  wire logic        HAND_MODE,
  input  wire logic        BYPASS_MODE,
  input  wire logic        RUN_CMD,
  input  wire logic        SMOKE_PURGE,
  input  wire logic        ROTATION_REVERSED,
  input  wire logic        BLACKOUT_DET,
  input  wire logic        BROWNOUT_DET,
  input  wire logic        WELD_SENSE,
  // sensed quantities (from same-clock sensing logic)
  input  wire logic [15:0] ANALOG_REF,
  input  wire logic [15:0] AUTO_REF,
  input  wire logic [15:0] PHASE_A_RMS,
  input  wire logic [15:0] PHASE_B_RMS,
  input  wire logic [15:0] PHASE_C_RMS,
  input  wire logic [15:0] MOTOR_RATED_CURRENT,
  // outputs to plant
  output logic      [15:0] FREQ_REF,
  output logic             BYPASS_CONTACTOR,
  output logic             SOFT_STARTER_RUN,
  output logic             CABINET_FAN,
  output logic             ENERGY_SAVE_EN,
  output logic             COAST_STOP,
  output logic             DAMPER_OPEN_N,
  output logic      [7:0]  DAMPER_OUT_MASK,
  output logic      [2:0]  CONTRAST_OUT,
  output faults_s          FAULTS
);

  // whole module state
  typedef struct packed {
    cfg_s        cfg;
    faults_s     flt;
    seq_e        seq;
    logic [31:0] rdata;
    logic        ack;
    logic [24:0] pre;
    logic        tick;
    logic [15:0] seq_cnt;
    logic [15:0] unbal_cnt;
    logic [15:0] load_cnt;
    logic [15:0] rst_cnt;
    logic [6:0]  unbal_pct;
    logic        in_restart;
    logic        weld_armed;
    logic        was_bypass_run;
    logic [15:0] freq_ref;
    logic        coil_ok;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // limit a value into an inclusive range
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  // each 6-bit din code holds only 0..36; larger writes saturate
  function automatic logic [23:0] din_clip(input logic [23:0] v);
    logic [23:0] r;
    r = v;
    for (int i = 0; i < 4; i++) begin
      if (v[i*6 +: 6] > DIN_CODE_MAX) r[i*6 +: 6] = DIN_CODE_MAX;
    end
    din_clip = r;
  endfunction : din_clip

  // synchronised pins
  logic hand_s, byp_s, run_s, smoke_s, rot_s, black_s, brown_s, weld_s;
  assign {hand_s, byp_s, run_s, smoke_s, rot_s, black_s, brown_s, weld_s} = s_reg.sync2;

  // unbalance arithmetic
  logic [15:0] i_max, i_min, i_diff;
  logic [22:0] i_scaled;
  logic [6:0]  pct;
  assign i_max    = (PHASE_A_RMS > PHASE_B_RMS) ? ((PHASE_A_RMS > PHASE_C_RMS) ? PHASE_A_RMS : PHASE_C_RMS)
                                               : ((PHASE_B_RMS > PHASE_C_RMS) ? PHASE_B_RMS : PHASE_C_RMS);
  assign i_min    = (PHASE_A_RMS < PHASE_B_RMS) ? ((PHASE_A_RMS < PHASE_C_RMS) ? PHASE_A_RMS : PHASE_C_RMS)
                                               : ((PHASE_B_RMS < PHASE_C_RMS) ? PHASE_B_RMS : PHASE_C_RMS);
  assign i_diff   = i_max - i_min;
  assign i_scaled = 23'(i_diff) * 23'd100;
  assign pct      = (i_max == 16'h0000) ? 7'h00 : 7'(i_scaled / 23'(i_max));

  // 5% of rated current, compared as i*20 < rated
  logic       current_low;
  logic [20:0] cur20;
  assign cur20       = 21'(i_max) * 21'd20;
  assign current_low = cur20 < 21'(MOTOR_RATED_CURRENT) * 21'd1 + 21'(0);

  logic supply_bad;
  assign supply_bad = black_s | brown_s;

  always_comb begin
    logic        wr, rd, bypass_run, bypass_start, rot_bad;
    logic [31:0] wd;
    s_next = s_reg;
    // write lands on the edge that shows waitrequest low
    wr = AVS_WRITE & s_reg.ack;
    rd = AVS_READ & ~s_reg.ack;
    wd = AVS_WRITEDATA;
    bypass_run = 1'b0;
    bypass_start = 1'b0;
    rot_bad = 1'b0;

    s_next.sync1 = {HAND_MODE, BYPASS_MODE, RUN_CMD, SMOKE_PURGE, ROTATION_REVERSED,
                    BLACKOUT_DET, BROWNOUT_DET, WELD_SENSE};
    s_next.sync2 = s_reg.sync1;

    // 100 ms tick keeps every timer narrow
    s_next.tick = 1'b0;
    if (s_reg.pre == 25'(TICK_CYCLES - 1)) begin
      s_next.pre  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.pre = s_reg.pre + 25'd1;
    end

    // bus slave: one wait cycle, answer on the following edge
    s_next.ack = (AVS_READ | AVS_WRITE) & ~s_reg.ack;
    if (rd) begin
      unique case (AVS_ADDRESS)
        OFS_MODE_CFG:   s_next.rdata = {19'h0, s_reg.cfg.display_contrast, s_reg.cfg.blackout_action_sel,
                                        s_reg.cfg.weld_detect_sel, s_reg.cfg.load_verify_sel,
                                        s_reg.cfg.phase_rotation_sel, s_reg.cfg.bypass_device_type,
                                        s_reg.cfg.hand_ref_source_sel, 2'h0};
        OFS_HAND_SPEED: s_next.rdata = {16'h0, s_reg.cfg.hand_speed_setpoint};
        OFS_SS_TIMES:   s_next.rdata = {s_reg.cfg.soft_stop_timeout, s_reg.cfg.soft_start_delay};
        OFS_UNBAL:      s_next.rdata = {s_reg.cfg.unbalance_trip_time, 6'h0, s_reg.cfg.unbalance_level};
        OFS_RESTART:    s_next.rdata = {23'h0, s_reg.cfg.restart_delay};
        OFS_DIN_LO:     s_next.rdata = {8'h0, s_reg.cfg.din_function_sel[23:0]};
        OFS_DIN_HI:     s_next.rdata = {8'h0, s_reg.cfg.din_function_sel[47:24]};
        OFS_STATUS:     s_next.rdata = {21'h0, s_reg.seq, 1'b0, s_reg.flt};
        OFS_UNBAL_NOW:  s_next.rdata = {25'h0, s_reg.unbal_pct};
        default:        s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (AVS_ADDRESS)
        OFS_MODE_CFG: begin
          if (AVS_BYTEENABLE[0]) begin
            s_next.cfg.hand_ref_source_sel = wd[2];
            s_next.cfg.bypass_device_type  = (wd[4:3] == 2'h3) ? 2'h2 : wd[4:3];
            s_next.cfg.phase_rotation_sel  = (wd[6:5] == 2'h3) ? 2'h2 : wd[6:5];
            s_next.cfg.load_verify_sel     = wd[7];
          end
          if (AVS_BYTEENABLE[1]) begin
            s_next.cfg.weld_detect_sel     = wd[8];
            s_next.cfg.blackout_action_sel = wd[9];
            s_next.cfg.display_contrast    = 3'(clamp16(16'(wd[12:10]), 16'h1, 16'h5));
          end
        end
        OFS_HAND_SPEED: if (&AVS_BYTEENABLE[1:0]) s_next.cfg.hand_speed_setpoint = wd[15:0];
        OFS_SS_TIMES: begin
          if (&AVS_BYTEENABLE[1:0]) s_next.cfg.soft_start_delay  = clamp16(wd[15:0], 16'h0, 16'h0258);
          if (&AVS_BYTEENABLE[3:2]) s_next.cfg.soft_stop_timeout = clamp16(wd[31:16], 16'h000A, 16'h0258);
        end
        OFS_UNBAL: begin
          if (&AVS_BYTEENABLE[1:0]) s_next.cfg.unbalance_level = 10'(clamp16({6'h0, wd[9:0]}, 16'h0032, 16'h01F4));
          if (&AVS_BYTEENABLE[3:2]) s_next.cfg.unbalance_trip_time = clamp16(wd[31:16], 16'h0, 16'h012C);
        end
        OFS_RESTART: if (&AVS_BYTEENABLE[1:0]) s_next.cfg.restart_delay = 9'(clamp16({7'h0, wd[8:0]}, 16'h1, 16'h012C));
        OFS_DIN_LO: if (&AVS_BYTEENABLE[2:0]) s_next.cfg.din_function_sel[23:0] = din_clip(wd[23:0]);
        OFS_DIN_HI: if (&AVS_BYTEENABLE[2:0]) s_next.cfg.din_function_sel[47:24] = din_clip(wd[23:0]);
        OFS_FAULT_CLR: begin
          // weld fault is not cleared here: only a RESET_N reset clears it
          if (wd[6]) s_next.flt.phase_loss_fault = 1'b0;
          if (wd[5]) s_next.flt.rotation_alarm   = 1'b0;
          if (wd[4]) s_next.flt.rotation_fault   = 1'b0;
          if (wd[3]) s_next.flt.load_lost_fault  = 1'b0;
          if (wd[1]) s_next.flt.supply_fault_a   = 1'b0;
          if (wd[0]) s_next.flt.supply_fault_b   = 1'b0;
        end
        default: ;
      endcase
    end

    // reference selection
    if (hand_s) s_next.freq_ref = s_reg.cfg.hand_ref_source_sel ? ANALOG_REF : s_reg.cfg.hand_speed_setpoint;
    else        s_next.freq_ref = AUTO_REF;

    // supply loss: fault or timed restart; restart timer starts at recovery
    if (supply_bad) begin
      s_next.coil_ok = 1'b0;
      s_next.rst_cnt = '0;
      if (!s_reg.cfg.blackout_action_sel || brown_s) begin
        if (black_s) s_next.flt.supply_fault_a = 1'b1;
        if (brown_s) s_next.flt.supply_fault_b = 1'b1;
      end else begin
        s_next.in_restart = 1'b1;
      end
    end else if (s_reg.in_restart) begin
      if (s_reg.tick) s_next.rst_cnt = s_reg.rst_cnt + 16'd1;
      if (s_reg.rst_cnt >= 16'(s_reg.cfg.restart_delay) * SEC_TICKS) begin
        s_next.in_restart = 1'b0;
        s_next.coil_ok    = 1'b1;
        s_next.rst_cnt    = '0;
      end
    end else if (!(s_reg.flt.supply_fault_a | s_reg.flt.supply_fault_b)) begin
      s_next.coil_ok = 1'b1;
    end

    // soft-ramp sequence
    bypass_run = byp_s & run_s & s_reg.coil_ok & ~COAST_STOP;
    unique case (s_reg.seq)
      SQ_IDLE: begin
        s_next.seq_cnt = '0;
        if (bypass_run) begin
          bypass_start = 1'b1;
          s_next.seq   = (s_reg.cfg.bypass_device_type == 2'h2) ? SQ_CLOSE : SQ_RUN;
        end
      end
      SQ_CLOSE: begin
        if (s_reg.tick) s_next.seq_cnt = s_reg.seq_cnt + 16'd1;
        if (!bypass_run) s_next.seq = SQ_IDLE;
        else if (s_reg.seq_cnt >= s_reg.cfg.soft_start_delay) s_next.seq = SQ_RUN;
      end
      SQ_RUN: begin
        s_next.seq_cnt = '0;
        if (!bypass_run)
          s_next.seq = (s_reg.cfg.bypass_device_type == 2'h2 && s_reg.coil_ok && !COAST_STOP) ? SQ_STOP : SQ_IDLE;
      end
      SQ_STOP: begin
        if (s_reg.tick) s_next.seq_cnt = s_reg.seq_cnt + 16'd1;
        if (current_low || !s_reg.coil_ok) s_next.seq = SQ_IDLE;
        else if (s_reg.seq_cnt >= s_reg.cfg.soft_stop_timeout) s_next.seq = SQ_COAST;
      end
      SQ_COAST: s_next.seq = SQ_IDLE;
      default:  s_next.seq = SQ_IDLE;
    endcase

    // phase rotation at bypass start only
    rot_bad = bypass_start & rot_s;
    if (rot_bad && s_reg.cfg.phase_rotation_sel == 2'h1) s_next.flt.rotation_alarm = 1'b1;
    if (rot_bad && s_reg.cfg.phase_rotation_sel == 2'h2) s_next.flt.rotation_fault = 1'b1;

    // unbalance trip timer
    s_next.unbal_pct = pct;
    if (s_reg.seq == SQ_RUN && s_reg.cfg.unbalance_trip_time != 16'h0 &&
        {3'h0, s_reg.unbal_pct, 3'h0} + {5'h0, s_reg.unbal_pct, 1'b0} > {3'h0, s_reg.cfg.unbalance_level}) begin
      if (s_reg.tick) s_next.unbal_cnt = s_reg.unbal_cnt + 16'd1;
      if (s_reg.unbal_cnt > s_reg.cfg.unbalance_trip_time) s_next.flt.phase_loss_fault = 1'b1;
    end else begin
      s_next.unbal_cnt = '0;
    end

    // load verification
    if (s_reg.cfg.load_verify_sel && !s_reg.sync2[4] && s_reg.seq == SQ_RUN &&
        (i_max == 16'h0 || s_reg.freq_ref == 16'h0)) begin
      if (s_reg.tick) s_next.load_cnt = s_reg.load_cnt + 16'd1;
      if (s_reg.load_cnt > LOAD_LOST_TICKS) s_next.flt.load_lost_fault = 1'b1;
    end else begin
      s_next.load_cnt = '0;
    end

    // welded contactor: armed at power-up and on leaving bypass run
    s_next.was_bypass_run = (s_reg.seq == SQ_RUN);
    if (s_reg.was_bypass_run && s_reg.seq != SQ_RUN) s_next.weld_armed = 1'b1;
    if (s_reg.weld_armed && s_reg.seq != SQ_RUN && s_reg.seq != SQ_STOP) begin
      s_next.weld_armed = 1'b0;
      if (s_reg.cfg.weld_detect_sel && weld_s) s_next.flt.weld_fault = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      s_reg                         <= '0;
      s_reg.seq                     <= SQ_IDLE;
      s_reg.weld_armed              <= 1'b1;
      s_reg.cfg.display_contrast    <= RST_CONTRAST;
      s_reg.cfg.hand_speed_setpoint <= RST_HAND_SPEED;
      s_reg.cfg.soft_start_delay    <= RST_SS_DELAY;
      s_reg.cfg.soft_stop_timeout   <= RST_SS_TIMEOUT;
      s_reg.cfg.unbalance_level     <= RST_UNBAL_LEVEL;
      s_reg.cfg.unbalance_trip_time <= RST_UNBAL_TIME;
      s_reg.cfg.restart_delay       <= RST_RESTART_S;
      s_reg.cfg.din_function_sel    <= RST_DIN_SEL;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  logic any_trip;
  assign any_trip = s_reg.flt.phase_loss_fault | s_reg.flt.rotation_fault | s_reg.flt.load_lost_fault |
                    s_reg.flt.weld_fault | s_reg.flt.supply_fault_a | s_reg.flt.supply_fault_b;

  always_comb begin
    DAMPER_OUT_MASK = 8'h00;
    for (int i = 0; i < 8; i++) begin
      DAMPER_OUT_MASK[i] = (s_reg.cfg.din_function_sel[i*6 +: 6] == DIN_DAMPER);
    end
  end

  assign AVS_READDATA     = s_reg.rdata;
  assign AVS_WAITREQUEST  = (AVS_READ | AVS_WRITE) & ~s_reg.ack;
  assign FREQ_REF         = s_reg.freq_ref;
  assign COAST_STOP       = any_trip | (s_reg.seq == SQ_COAST);
  assign BYPASS_CONTACTOR = s_reg.coil_ok & ~any_trip &
                            (s_reg.seq == SQ_CLOSE || s_reg.seq == SQ_RUN || s_reg.seq == SQ_STOP);
  assign SOFT_STARTER_RUN = BYPASS_CONTACTOR & (s_reg.cfg.bypass_device_type == 2'h2) &
                            (s_reg.seq == SQ_RUN);
  assign CABINET_FAN      = (s_reg.cfg.bypass_device_type != 2'h0) | ~s_reg.sync2[6];
  assign ENERGY_SAVE_EN   = (s_reg.cfg.bypass_device_type != 2'h2);
  assign DAMPER_OPEN_N    = s_reg.flt.load_lost_fault;
  assign CONTRAST_OUT     = s_reg.cfg.display_contrast;
  assign FAULTS           = s_reg.flt;

endmodule : bypass_protection_sequencer

// [inc/bypass_pkg.sv]
// package: register map, field codes, timing constants and carriers of the bypass sequencer
package bypass_pkg;

  // time base
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned LOAD_LOST_S    = 10;
  localparam logic [15:0] LOAD_LOST_TICKS = 16'(LOAD_LOST_S * 1000 / TICK_MS);
  localparam logic [15:0] SEC_TICKS      = 16'(1000 / TICK_MS);

  // register byte offsets
  localparam logic [5:0] OFS_MODE_CFG   = 6'h00;
  localparam logic [5:0] OFS_HAND_SPEED = 6'h04;
  localparam logic [5:0] OFS_SS_TIMES   = 6'h08;
  localparam logic [5:0] OFS_UNBAL      = 6'h0C;
  localparam logic [5:0] OFS_RESTART    = 6'h10;
  localparam logic [5:0] OFS_DIN_LO     = 6'h14;
  localparam logic [5:0] OFS_DIN_HI     = 6'h18;
  localparam logic [5:0] OFS_STATUS     = 6'h1C;
  localparam logic [5:0] OFS_FAULT_CLR  = 6'h20;
  localparam logic [5:0] OFS_UNBAL_NOW  = 6'h24;

  // reset values (times in 0.1 s ticks unless noted)
  localparam logic [15:0] RST_HAND_SPEED   = 16'h0000;
  localparam logic [15:0] RST_SS_DELAY     = 16'h0014;
  localparam logic [15:0] RST_SS_TIMEOUT   = 16'h0096;
  localparam logic [9:0]  RST_UNBAL_LEVEL  = 10'h0FA;
  localparam logic [15:0] RST_UNBAL_TIME   = 16'h0032;
  localparam logic [8:0]  RST_RESTART_S    = 9'h00A;
  localparam logic [2:0]  RST_CONTRAST     = 3'h3;
  localparam logic [47:0] RST_DIN_SEL      = 48'h740019_617595;
  localparam logic [5:0]  DIN_CODE_MAX     = 6'h24;
  localparam logic [5:0]  DIN_DAMPER       = 6'h14;

  // soft-ramp sequence states
  typedef enum logic [2:0] {
    SQ_IDLE    = 3'b000,
    SQ_CLOSE   = 3'b001,
    SQ_RUN     = 3'b010,
    SQ_STOP    = 3'b011,
    SQ_COAST   = 3'b100
  } seq_e;

  typedef struct packed {
    logic        hand_ref_source_sel;
    logic [1:0]  bypass_device_type;
    logic [1:0]  phase_rotation_sel;
    logic        load_verify_sel;
    logic        weld_detect_sel;
    logic        blackout_action_sel;
    logic [2:0]  display_contrast;
    logic [15:0] hand_speed_setpoint;
    logic [15:0] soft_start_delay;
    logic [15:0] soft_stop_timeout;
    logic [9:0]  unbalance_level;
    logic [15:0] unbalance_trip_time;
    logic [8:0]  restart_delay;
    logic [47:0] din_function_sel;
  } cfg_s;

  typedef struct packed {
    logic phase_loss_fault;
    logic rotation_alarm;
    logic rotation_fault;
    logic load_lost_fault;
    logic weld_fault;
    logic supply_fault_a;
    logic supply_fault_b;
  } faults_s;

endpackage : bypass_pkg

// [tb/bypass_monitor.sv]
// checker: bus handshake, coil interlocks and fault behaviour at the sequencer ports
`timescale 1ns/100ps
module bypass_monitor
  import bypass_pkg::*;
(
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET_N,
  // register bus
  input wire logic [5:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  // plant side
  input wire logic        BYPASS_CONTACTOR,
  input wire logic        SOFT_STARTER_RUN,
  input wire logic        ENERGY_SAVE_EN,
  input wire logic        COAST_STOP,
  input wire logic [2:0]  CONTRAST_OUT,
  input wire faults_s     FAULTS
);
  logic [1:0] dev_type_reg;
  // shadow of the type field; only valid codes are assumed, 3 would saturate
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) dev_type_reg <= 2'h0;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_MODE_CFG && AVS_BYTEENABLE[0])
      dev_type_reg <= AVS_WRITEDATA[4:3];
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  sequence s_req_start; $rose(AVS_READ || AVS_WRITE); endsequence
  sequence s_req_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST ##1 (AVS_READ || AVS_WRITE); endsequence
  sequence s_coils_off; !BYPASS_CONTACTOR && !SOFT_STARTER_RUN; endsequence
  property p_wait_first; s_req_start |-> AVS_WAITREQUEST; endproperty
  property p_wait_answer; s_req_wait |-> !AVS_WAITREQUEST; endproperty
  property p_contrast; CONTRAST_OUT inside {[3'h1:3'h5]}; endproperty
  property p_energy; (dev_type_reg == 2'h2) [*3] |-> !ENERGY_SAVE_EN; endproperty
  property p_weld_latch; FAULTS.weld_fault |=> FAULTS.weld_fault; endproperty
  property p_supply_off; $rose(FAULTS.supply_fault_a || FAULTS.supply_fault_b) |-> ##[0:2] s_coils_off; endproperty
  property p_ss_contactor; SOFT_STARTER_RUN |-> BYPASS_CONTACTOR; endproperty
  property p_rot_coast; $rose(FAULTS.rotation_fault) |-> ##[0:2] COAST_STOP; endproperty
  a_wait_first: assert property (p_wait_first) else $error("waitrequest low in first request cycle");
  a_wait_answer: assert property (p_wait_answer) else $error("no answer in second request cycle");
  a_contrast: assert property (p_contrast) else $error("contrast out of range");
  a_energy: assert property (p_energy) else $error("energy savings on with type 2");
  a_weld_latch: assert property (p_weld_latch) else $error("weld fault cleared without reset");
  a_supply_off: assert property (p_supply_off) else $error("coils kept on after supply fault");
  a_ss_contactor: assert property (p_ss_contactor) else $error("soft starter on with contactor open");
  a_rot_coast: assert property (p_rot_coast) else $error("rotation fault without coast");
endmodule : bypass_monitor
bind bypass_protection_sequencer bypass_monitor mon_u (.CLK_SYS, .RESET_N, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_WAITREQUEST, .BYPASS_CONTACTOR, .SOFT_STARTER_RUN,
  .ENERGY_SAVE_EN, .COAST_STOP, .CONTRAST_OUT, .FAULTS);

// [tb/bypass_plant_model.sv]
// plant model: bypass contactor feedback and phase current sensing
`timescale 1ns/100ps
module bypass_plant_model (
  // coil command and plant state
  input  wire logic        contactor_cmd,
  input  wire logic        welded,
  input  wire logic [15:0] load_ab,
  input  wire logic [15:0] load_c,
  // sensing back to the sequencer
  output logic      [15:0] phase_a,
  output logic      [15:0] phase_b,
  output logic      [15:0] phase_c,
  output logic             weld_sense
);
  logic path_closed;
  // a stuck tip keeps current flowing after the coil drops
  assign path_closed = contactor_cmd | welded;
  assign phase_a     = path_closed ? load_ab : 16'h0000;
  assign phase_b     = path_closed ? load_ab : 16'h0000;
  assign phase_c     = path_closed ? load_c : 16'h0000;
  assign weld_sense  = path_closed;
endmodule : bypass_plant_model

// [tb/bypass_protection_sequencer_tb_top.sv]
// testbench: register defaults, reference, device type, rotation, weld and supply sequences
`timescale 1ns/100ps
module bypass_protection_sequencer_tb_top
  import bypass_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        hand_mode = 1'b0, bypass_mode = 1'b0, run_cmd = 1'b0, rot_rev = 1'b0;
  logic        blk = 1'b0, brn = 1'b0, welded = 1'b0, weld_sense, contactor, soft_run, fan, esave, coast;
  logic [15:0] analog_ref = 16'h0ABC, load_ab = 16'h0064, load_c = 16'h0032, freq_ref, ph_a, ph_b, ph_c;
  logic [2:0]  contrast;
  faults_s     faults;
  logic [31:0] rv [7] = '{32'h0000_0C00, 32'h0, 32'h0096_0014, 32'h0032_00FA, 32'h0000_000A,
                          32'h0061_7595, 32'h0074_0019};
  int          num_errors = 0;
  int          samples_checked = 0;
  always #2 clk_sys = ~clk_sys;
  bypass_protection_sequencer dut_u (.CLK_SYS(clk_sys), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .HAND_MODE(hand_mode),
    .BYPASS_MODE(bypass_mode), .RUN_CMD(run_cmd), .SMOKE_PURGE(1'b0), .ROTATION_REVERSED(rot_rev),
    .BLACKOUT_DET(blk), .BROWNOUT_DET(brn), .WELD_SENSE(weld_sense), .ANALOG_REF(analog_ref),
    .AUTO_REF(16'h0200), .PHASE_A_RMS(ph_a), .PHASE_B_RMS(ph_b), .PHASE_C_RMS(ph_c),
    .MOTOR_RATED_CURRENT(16'h0064), .FREQ_REF(freq_ref), .BYPASS_CONTACTOR(contactor),
    .SOFT_STARTER_RUN(soft_run), .CABINET_FAN(fan), .ENERGY_SAVE_EN(esave), .COAST_STOP(coast),
    .DAMPER_OPEN_N(), .DAMPER_OUT_MASK(), .CONTRAST_OUT(contrast), .FAULTS(faults));
  bypass_plant_model plant_u (.contactor_cmd(contactor), .welded(welded), .load_ab(load_ab),
    .load_c(load_c), .phase_a(ph_a), .phase_b(ph_b), .phase_c(ph_c), .weld_sense(weld_sense));
  task automatic conclude();
    $display("errors %0d of %0d checks", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) chk(32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : settle
  initial begin
    settle(10);
    reset_n <= 1'b1;
    for (int i = 0; i < 7; i++) rd(6'(i * 4), rv[i]);
    rd(6'h3C, 32'h0);
    foreach (rv[i]) if (i < 3) begin
      wr(OFS_MODE_CFG, 32'(i * 5 + 2) << 10);
      settle(4);
      chk(32'(contrast), (i == 0) ? 32'h2 : ((i == 1) ? 32'h5 : 32'h4));
    end
    hand_mode <= 1'b1;
    wr(OFS_HAND_SPEED, 32'h1234);
    wr(OFS_MODE_CFG, 32'h0C00);
    settle(8);
    chk(32'(freq_ref), 32'h1234);
    wr(OFS_MODE_CFG, 32'h0C04);
    settle(8);
    chk(32'(freq_ref), 32'h0ABC);
    hand_mode <= 1'b0;
    bypass_mode <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      wr(OFS_MODE_CFG, 32'h0C00 | 32'(t) << 3);
      settle(8);
      if (t < 2) chk(32'(fan), 32'(t));
      else chk(32'(esave), 32'h0);
    end
    run_cmd <= 1'b1;
    settle(20);
    chk({contactor, soft_run}, 32'h2);
    run_cmd <= 1'b0;
    load_ab <= 16'h0000;
    load_c <= 16'h0000;
    settle(20);
    wr(OFS_SS_TIMES, 32'h0096_0000);
    run_cmd <= 1'b1;
    settle(20);
    chk({contactor, soft_run}, 32'h3);
    run_cmd <= 1'b0;
    settle(20);
    load_ab <= 16'h0064;
    load_c <= 16'h0032;
    rot_rev <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      wr(OFS_FAULT_CLR, 32'h7F);
      wr(OFS_MODE_CFG, 32'h0C00 | 32'(s) << 5);
      run_cmd <= 1'b1;
      settle(10);
      chk({faults.rotation_alarm, faults.rotation_fault, coast}, (s == 1) ? 32'h4 : 32'(s) * 3 / 2);
      if (s == 0) rd(OFS_UNBAL_NOW, 32'd50);
      run_cmd <= 1'b0;
      settle(10);
    end
    bypass_mode <= 1'b0;
    wr(OFS_FAULT_CLR, 32'h7F);
    run_cmd <= 1'b1;
    settle(10);
    chk(32'(faults.rotation_fault), 32'h0);
    run_cmd <= 1'b0;
    rot_rev <= 1'b0;
    bypass_mode <= 1'b1;
    wr(OFS_MODE_CFG, 32'h0D00);
    run_cmd <= 1'b1;
    settle(10);
    welded <= 1'b1;
    run_cmd <= 1'b0;
    settle(20);
    chk(32'(faults.weld_fault), 32'h1);
    wr(OFS_FAULT_CLR, 32'h7F);
    settle(4);
    chk(32'(faults.weld_fault), 32'h1);
    welded <= 1'b0;
    reset_n <= 1'b0;
    settle(3);
    reset_n <= 1'b1;
    settle(8);
    chk(32'(faults.weld_fault), 32'h0);
    // supply loss with the coil closed: fault select, brownout, then restart select
    for (int k = 0; k < 3; k++) begin
      wr(OFS_FAULT_CLR, 32'h7F);
      wr(OFS_MODE_CFG, (k == 2) ? 32'h0E00 : 32'h0C00);
      run_cmd <= 1'b1;
      settle(10);
      chk(32'(contactor), 32'h1);
      if (k == 1) brn <= 1'b1;
      else blk <= 1'b1;
      settle(10);
      chk({faults.supply_fault_a | faults.supply_fault_b, contactor}, (k < 2) ? 32'h2 : {31'h0, 1'b0});
      chk(32'(contactor | soft_run), 32'h0);
      blk <= 1'b0;
      brn <= 1'b0;
      settle(10);
      if (k == 2) chk(32'(contactor), 32'h0);
      run_cmd <= 1'b0;
      settle(10);
    end
    conclude();
  end
  initial begin
    #200_000;
    num_errors++;
    conclude();
  end
endmodule : bypass_protection_sequencer_tb_top
